//--- bench/fsc_flash_model.sv
// Behavioural model of the program flash array behind the controller.
// Assumes commands and strobes come from fsc_flash_ctrl on the rising edge of i_mclk.
`timescale 1ns/1ps
module fsc_flash_model
   import fsc_pkg::*;
(
   input wire logic i_mclk,
   input wire fsc_pkg::fsc_cmd_e i_fl_cmd,
   input wire logic [23:0] i_fl_addr,
   input wire logic [23:0] i_fl_wdata,
   input wire logic i_fl_wr,
   input wire logic i_fl_rd,
   output logic [23:0] o_fl_rdata
);
   // ************************************************************
   // Storage: unwritten words read as erased.
   // ************************************************************
   logic [23:0] mem [logic [22:0]];
   fsc_cmd_e last_cmd = FSC_CMD_NONE;
   logic [23:0] last_addr = 24'h000000;
   logic [23:0] junk = 24'h5A5A5A;

   // Words program on each strobe; a page of 512 words erases as its command ends.
   always @(posedge i_mclk) begin
      if (i_fl_wr === 1'b1) begin
         mem[i_fl_addr[23:1]] = i_fl_wdata;
      end
      if (last_cmd == FSC_CMD_PAGE_ERASE && i_fl_cmd != FSC_CMD_PAGE_ERASE) begin
         for (int i = 0; i < 512; i++) begin
            mem[{last_addr[23:10], 9'h000} + 23'(i)] = 24'hFFFFFF;
         end
      end
      last_cmd = i_fl_cmd;
      last_addr = i_fl_addr;
      junk = ~junk;
   end

   // Read data is valid only while the read strobe is high; otherwise it keeps changing.
   always @(*) begin
      if (i_fl_rd === 1'b1) begin
         o_fl_rdata = mem.exists(i_fl_addr[23:1]) ? mem[i_fl_addr[23:1]] : 24'hFFFFFF;
      end else begin
         o_fl_rdata = junk;
      end
   end
endmodule // fsc_flash_model

//--- bench/testbench.sv
// Self-checking testbench of the flash self-programming controller.
// Assumes fsc_pkg is compiled first and the flash array model stands beside the design.
`timescale 1ns/1ps
module testbench;
   import fsc_pkg::*;
   // ************************************************************
   // Signals, clocks and the design under test.
   // ************************************************************
   logic i_mclk = 1'b0, i_rst_b = 1'b0, i_rc_osc = 1'b0;
   logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_tbl_req = 1'b0, i_tbl_write = 1'b0;
   logic i_tbl_high = 1'b0, i_tbl_byte = 1'b0, i_tbl_bsel = 1'b0;
   logic [1:0] i_reg_sel = 2'h0;
   logic [15:0] i_reg_wdata = 16'h0000, i_tbl_ea = 16'h0000, i_tbl_wdata = 16'h0000;
   logic [15:0] o_reg_rdata, o_tbl_rdata, d;
   logic o_tbl_done, o_core_stall, o_fl_wr, o_fl_rd;
   logic [23:0] o_fl_addr, o_fl_wdata, i_fl_rdata;
   fsc_cmd_e o_fl_cmd;
   int err_total = 0, checked = 0, wr_cnt = 0, exp_cnt, lat;

   // Core clock at 200 MHz and a free-running internal RC oscillator near 7.37 MHz.
   always #2.5 i_mclk = ~i_mclk;
   always #67.8 i_rc_osc = ~i_rc_osc;

   // Count programming strobes sent to the array.
   always @(posedge i_mclk) begin
      if (o_fl_wr === 1'b1) begin
         wr_cnt++;
      end
   end

   fsc_flash_ctrl #(.ROW_RC_CYCLES(16'h0004), .WORD_RC_CYCLES(16'h0002),
      .ERASE_RC_CYCLES(16'h0004)) i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_sel(i_reg_sel),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_tbl_req(i_tbl_req),
      .i_tbl_write(i_tbl_write), .i_tbl_high(i_tbl_high), .i_tbl_byte(i_tbl_byte),
      .i_tbl_bsel(i_tbl_bsel), .i_tbl_ea(i_tbl_ea), .i_tbl_wdata(i_tbl_wdata),
      .o_tbl_rdata(o_tbl_rdata), .o_tbl_done(o_tbl_done), .o_core_stall(o_core_stall),
      .i_rc_osc(i_rc_osc), .o_fl_cmd(o_fl_cmd), .o_fl_addr(o_fl_addr),
      .o_fl_wdata(o_fl_wdata), .o_fl_wr(o_fl_wr), .o_fl_rd(o_fl_rd),
      .i_fl_rdata(i_fl_rdata));

   fsc_flash_model i_array (.i_mclk(i_mclk), .i_fl_cmd(o_fl_cmd), .i_fl_addr(o_fl_addr),
      .i_fl_wdata(o_fl_wdata), .i_fl_wr(o_fl_wr), .i_fl_rd(o_fl_rd),
      .o_fl_rdata(i_fl_rdata));

   // ************************************************************
   // Access tasks and comparison.
   // ************************************************************
   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Compares a seen value with the expected one.
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One register write pulse.
   task automatic reg_wr(input logic [1:0] sel, input logic [15:0] v);
      @(negedge i_mclk);
      i_reg_sel = sel;
      i_reg_wdata = v;
      i_reg_wr = 1'b1;
      @(negedge i_mclk);
      i_reg_wr = 1'b0;
   endtask

   // One register read; data is taken the cycle after the strobe.
   task automatic reg_rd(input logic [1:0] sel, output logic [15:0] v);
      @(negedge i_mclk);
      i_reg_sel = sel;
      i_reg_rd = 1'b1;
      @(negedge i_mclk);
      i_reg_rd = 1'b0;
      v = o_reg_rdata;
   endtask

   // One table access; lat returns the cycles until done less one; a timeout ends the test.
   task automatic tbl(input logic wr, hi, byt, bs, input logic [15:0] ea, wd);
      @(negedge i_mclk);
      {i_tbl_write, i_tbl_high, i_tbl_byte, i_tbl_bsel} = {wr, hi, byt, bs};
      i_tbl_ea = ea;
      i_tbl_wdata = wd;
      i_tbl_req = 1'b1;
      lat = -1;
      for (int i = 0; i < 8 && lat < 0; i++) begin
         @(negedge i_mclk);
         i_tbl_req = 1'b0;
         if (o_tbl_done === 1'b1) begin
            lat = i;
         end
      end
      d = o_tbl_rdata;
      if (lat < 0) begin
         err_total++;
         end_of_test();
      end
   endtask

   // Unlock with both key bytes, then write the control register.
   task automatic start(input logic [15:0] v);
      reg_wr(FSC_SEL_KEY, 16'h0055);
      reg_wr(FSC_SEL_KEY, 16'h00AA);
      reg_wr(FSC_SEL_CTRL, v);
      repeat (2) @(negedge i_mclk);
   endtask

   // Waits, bounded, for the core stall to drop.
   task automatic wait_idle();
      int n;
      n = 0;
      while (o_core_stall !== 1'b0 && n < 20000) begin
         @(negedge i_mclk);
         n++;
      end
      if (n >= 20000) begin
         err_total++;
         end_of_test();
      end
      repeat (2) @(negedge i_mclk);
   endtask

   // ************************************************************
   // Test sequence.
   // ************************************************************
   initial begin
      repeat (12) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_b = 1'b1;
      // Reset values, key read-back and an unmapped select.
      reg_rd(FSC_SEL_CTRL, d); check(d, 24'h0);
      reg_wr(FSC_SEL_KEY, 16'hFF55);
      reg_rd(FSC_SEL_KEY, d); check(d, 24'h0);
      reg_rd(2'h3, d); check(d, 24'h0);
      $display("test reset done");
      // Row program: 64 low and 64 high writes into page 1, row 1.
      reg_wr(FSC_SEL_CTRL, 16'h4001);
      reg_wr(FSC_SEL_PAGE, 16'h0001);
      for (int i = 0; i < 64; i++) begin
         tbl(1, 0, 0, 0, 16'h0080 + 16'(2 * i), 16'hA000 + 16'(i));
         check(24'(lat), 24'h0);
         tbl(1, 1, 0, 0, 16'h0080 + 16'(2 * i), 16'(i));
      end
      check(24'(wr_cnt), 24'h0);
      start(16'hC001);
      check(24'(o_core_stall), 24'h1);
      reg_wr(FSC_SEL_CTRL, 16'h4001);
      reg_rd(FSC_SEL_CTRL, d); check(d, 24'hC001);
      wait_idle();
      check(24'(wr_cnt), 24'd64);
      reg_rd(FSC_SEL_CTRL, d); check(d, 24'h4001);
      tbl(0, 0, 0, 0, 16'h008A, 16'h0); check(d, 24'hA005);
      tbl(0, 0, 1, 1, 16'h008A, 16'h0); check(d, 24'h00A0);
      tbl(0, 0, 1, 0, 16'h008A, 16'h0); check(d, 24'h0005);
      tbl(0, 1, 0, 0, 16'h008A, 16'h0); check(d, 24'h0005);
      tbl(0, 1, 1, 1, 16'h008A, 16'h0); check(d, 24'h0000);
      reg_wr(FSC_SEL_PAGE, 16'h0000);
      tbl(0, 0, 0, 0, 16'h008A, 16'h0); check(d, 24'hFFFF);
      reg_wr(FSC_SEL_PAGE, 16'h0001);
      $display("test row done");
      // Single word program inside the same page.
      reg_wr(FSC_SEL_CTRL, 16'h4003);
      tbl(1, 0, 0, 0, 16'h0200, 16'h1234);
      tbl(1, 1, 0, 0, 16'h0200, 16'h0056);
      start(16'hC003);
      wait_idle();
      check(24'(wr_cnt), 24'd65);
      tbl(0, 0, 0, 0, 16'h0200, 16'h0); check(d, 24'h1234);
      tbl(0, 1, 0, 0, 16'h0200, 16'h0); check(d, 24'h0056);
      $display("test word done");
      // Page erase pointed at an address inside the page, not its base.
      reg_wr(FSC_SEL_CTRL, 16'h4042);
      tbl(1, 0, 0, 0, 16'h0094, 16'h0000);
      start(16'hC042);
      wait_idle();
      tbl(0, 0, 0, 0, 16'h008A, 16'h0); check(d, 24'hFFFF);
      tbl(0, 1, 0, 0, 16'h0200, 16'h0); check(d, 24'h00FF);
      $display("test erase done");
      // Broken unlock, then a start without write enable.
      reg_wr(FSC_SEL_KEY, 16'h0055);
      reg_wr(FSC_SEL_PAGE, 16'h0001);
      reg_wr(FSC_SEL_KEY, 16'h00AA);
      reg_wr(FSC_SEL_CTRL, 16'hC001);
      check(24'(o_core_stall), 24'h0);
      reg_rd(FSC_SEL_CTRL, d); check(d, 24'h6001);
      start(16'h8001);
      reg_rd(FSC_SEL_CTRL, d); check(d, 24'h2001);
      check(24'(wr_cnt), 24'd65);
      $display("test refuse done");
      // Every operation code with erase clear; only listed codes program words.
      exp_cnt = 65;
      for (int c = 0; c < 16; c++) begin
         tbl(1, 0, 0, 0, 16'h0300, 16'h0F0F);
         start(16'hC000 | 16'(c));
         wait_idle();
         exp_cnt += (c == 0 || c == 3) ? 1 : (c == 1) ? 64 : 0;
         check(24'(wr_cnt), 24'(exp_cnt));
         reg_rd(FSC_SEL_CTRL, d); check(d, 24'h4000 | 24'(c));
      end
      $display("test codes done");
      end_of_test();
   end
endmodule // testbench

//--- common/fsc_pkg.sv
// Shared constants and types of the flash self-programming controller.
// Assumes a single 200 MHz core clock and an asynchronous active-low reset.
package fsc_pkg;

   // ************************************************************
   // Register selects of the special-function register port.
   // ************************************************************
   localparam logic [1:0] FSC_SEL_CTRL = 2'h0;
   localparam logic [1:0] FSC_SEL_KEY = 2'h1;
   localparam logic [1:0] FSC_SEL_PAGE = 2'h2;

   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int FSC_BIT_START = 15;
   localparam int FSC_BIT_OP_WRITE_ENABLE = 14;
   localparam int FSC_BIT_ERR = 13;
   localparam int FSC_BIT_ERASE = 6;
   localparam logic [3:0] FSC_OPSEL_RESET = 4'h0;
   localparam logic [7:0] FSC_PAGE_RESET = 8'h00;
   localparam logic [23:0] FSC_ADDR_RESET = 24'h000000;

   // Unlock key bytes.
   localparam logic [7:0] FSC_KEY_FIRST = 8'h55;
   localparam logic [7:0] FSC_KEY_SECOND = 8'hAA;

   // Alignment: a row spans 128 address units, a page 1024 (two per word).
   localparam int FSC_ROW_LSB = 7;
   localparam int FSC_PAGE_LSB = 10;

   // Operation-select codes.
   localparam logic [3:0] FSC_OPC_CFG = 4'h0;
   localparam logic [3:0] FSC_OPC_ROW = 4'h1;
   localparam logic [3:0] FSC_OPC_PAGE = 4'h2;
   localparam logic [3:0] FSC_OPC_WORD = 4'h3;
   localparam logic [3:0] FSC_OPC_SEC = 4'hC;
   localparam logic [3:0] FSC_OPC_GEN = 4'hD;
   localparam logic [3:0] FSC_OPC_BULK = 4'hF;

   // Self-timed durations in internal RC oscillator cycles.
   localparam logic [15:0] FSC_ROW_RC_CYCLES = 16'h2B38;
   localparam logic [15:0] FSC_WORD_RC_CYCLES = 16'h0200;
   localparam logic [15:0] FSC_ERASE_RC_CYCLES = 16'h2B38;

   // Command presented to the flash array.
   typedef enum logic [3:0] {
      FSC_CMD_NONE = 4'b0000,
      FSC_CMD_PAGE_ERASE = 4'b0001,
      FSC_CMD_BULK_ERASE = 4'b0010,
      FSC_CMD_GEN_ERASE = 4'b0011,
      FSC_CMD_SEC_ERASE = 4'b0100,
      FSC_CMD_CFG_ERASE = 4'b0101,
      FSC_CMD_WORD_PROG = 4'b0110,
      FSC_CMD_ROW_PROG = 4'b0111,
      FSC_CMD_CFG_PROG = 4'b1000
   } fsc_cmd_e;

   // Sequencer states.
   typedef enum logic [1:0] {
      FSC_ST_IDLE = 2'b00,
      FSC_ST_RUN = 2'b01,
      FSC_ST_DONE = 2'b10
   } fsc_state_e;

endpackage

//--- logic/fsc_flash_ctrl.sv
// Run-time self-programming controller for the on-chip program flash.
// Assumes the core drives register and table strobes on i_mclk, and the
// flash array returns read data combinationally in the cycle of o_fl_rd.
// Notes on behaviour
// RULE1: Array rows hold 64 words; a row is the row-program unit.
// RULE2: Erase works on eight-row pages; program works on a row or one word.
// RULE3: Pages and rows align on 1536/192-byte bounds; low address bits ignored.
// RULE4: A 64-word holding buffer is loaded in order within one aligned group.
// RULE5: Host fills a row with 64 low and 64 high table writes.
// RULE6: Table writes only touch the buffer and finish in two cycles.
// RULE7: Target address is table page on top of the 16-bit effective address.
// RULE8: Low table accesses reach bits 15..0, word or byte mode.
// RULE9: High table accesses reach bits 23..16, word or byte mode.
// RULE10: The core is stalled while an erase or program runs.
// RULE11: Start bit 15 launches the operation; hardware clears it at the end.
// RULE12: Software can only set the start bit, never clear it.
// RULE13: Error bit 13 sets on a bad sequence; clears on normal completion.
// RULE14: Erase-select bit 6 picks erase or program meanings of the code.
// RULE15: Program codes 0011 word, 0001 row, 0000 config byte; others no-op.
// RULE16: Unlisted codes are unimplemented and change nothing in flash.
// RULE17: A start is accepted only right after key writes 0x55 then 0xAA.
// RULE18: Key register is write-only in bits 7..0; upper bits read zero.
// RULE19: Row write lasts 11064 internal RC cycles, nominally 7.37 MHz.
// RULE20: Host erases a page with code 0010, erase and enable set, key, start.
// RULE21: Write-enable bit 14 must be set or program and erase are inhibited.
// RULE22: Host follows the start with two no-operation instructions.
// RULE23: Any other write between key bytes discards the partial unlock.
`timescale 1ns/1ps
module fsc_flash_ctrl #(
   parameter logic [15:0] ROW_RC_CYCLES = fsc_pkg::FSC_ROW_RC_CYCLES,
   parameter logic [15:0] WORD_RC_CYCLES = fsc_pkg::FSC_WORD_RC_CYCLES,
   parameter logic [15:0] ERASE_RC_CYCLES = fsc_pkg::FSC_ERASE_RC_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [1:0] i_reg_sel,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   input wire logic i_tbl_req,
   input wire logic i_tbl_write,
   input wire logic i_tbl_high,
   input wire logic i_tbl_byte,
   input wire logic i_tbl_bsel,
   input wire logic [15:0] i_tbl_ea,
   input wire logic [15:0] i_tbl_wdata,
   output logic [15:0] o_tbl_rdata,
   output logic o_tbl_done,
   output logic o_core_stall,
   input wire logic i_rc_osc,
   output fsc_pkg::fsc_cmd_e o_fl_cmd,
   output logic [23:0] o_fl_addr,
   output logic [23:0] o_fl_wdata,
   output logic o_fl_wr,
   output logic o_fl_rd,
   input wire logic [23:0] i_fl_rdata
);
   import fsc_pkg::*;

   // ************************************************************
   // Declarations.
   // ************************************************************
   fsc_state_e state_q;
   fsc_cmd_e cmd_q;
   fsc_cmd_e cmd_d;
   logic start_q, op_write_enable_q, err_q, erase_q;
   logic [3:0] opsel_q;
   logic [7:0] table_page_q;
   logic [23:0] tgt_q;
   logic key_half_q, key_armed_q;
   logic start_try, start_ok, start_bad, finish;
   logic tbl_go, tbl_rd1_q;
   logic rc_s1_q, rc_s2_q, rc_s3_q, rc_lvl_q, rc_rise;
   logic [15:0] rc_cnt_q;
   logic [15:0] lim_d;
   logic [6:0] idx_q;
   logic [23:0] buf_q [64];

   // ************************************************************
   // Internal RC oscillator synchroniser and edge count.
   // ************************************************************

   // Three flops; a rise counts once the second and third agree.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rc_s1_q <= 1'b0;
         rc_s2_q <= 1'b0;
         rc_s3_q <= 1'b0;
         rc_lvl_q <= 1'b0;
      end else begin
         rc_s1_q <= i_rc_osc;
         rc_s2_q <= rc_s1_q;
         rc_s3_q <= rc_s2_q;
         if (rc_s2_q == rc_s3_q) begin
            rc_lvl_q <= rc_s3_q;
         end
      end
   end
   assign rc_rise = rc_s2_q && rc_s3_q && !rc_lvl_q;

   // ************************************************************
   // Unlock key and start qualification.
   // ************************************************************

   // Any register write ends a half-done or armed unlock. [RULE17] [RULE23]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         key_half_q <= 1'b0;
         key_armed_q <= 1'b0;
      end else if (i_reg_wr) begin
         key_half_q <= (i_reg_sel == FSC_SEL_KEY) && (i_reg_wdata[7:0] == FSC_KEY_FIRST);
         key_armed_q <= key_half_q && (i_reg_sel == FSC_SEL_KEY)
                        && (i_reg_wdata[7:0] == FSC_KEY_SECOND);
      end
   end

   // A start needs the unlock and the enable bit of the same write. [RULE17] [RULE21]
   assign start_try = i_reg_wr && (i_reg_sel == FSC_SEL_CTRL)
                      && i_reg_wdata[FSC_BIT_START] && (state_q == FSC_ST_IDLE);
   assign start_ok = start_try && key_armed_q && i_reg_wdata[FSC_BIT_OP_WRITE_ENABLE];
   assign start_bad = start_try && !start_ok;

   // Decode erase-select and the code; unlisted codes become no change. [RULE14]
   always_comb begin
      cmd_d = FSC_CMD_NONE;
      if (i_reg_wdata[FSC_BIT_ERASE]) begin
         case (i_reg_wdata[3:0])
            FSC_OPC_PAGE: cmd_d = FSC_CMD_PAGE_ERASE; // [RULE2]
            FSC_OPC_BULK: cmd_d = FSC_CMD_BULK_ERASE;
            FSC_OPC_GEN: cmd_d = FSC_CMD_GEN_ERASE;
            FSC_OPC_SEC: cmd_d = FSC_CMD_SEC_ERASE;
            FSC_OPC_CFG: cmd_d = FSC_CMD_CFG_ERASE;
            default: cmd_d = FSC_CMD_NONE; // [RULE16]
         endcase
      end else begin
         case (i_reg_wdata[3:0])
            FSC_OPC_WORD: cmd_d = FSC_CMD_WORD_PROG; // [RULE15]
            FSC_OPC_ROW: cmd_d = FSC_CMD_ROW_PROG; // [RULE15]
            FSC_OPC_CFG: cmd_d = FSC_CMD_CFG_PROG; // [RULE15]
            default: cmd_d = FSC_CMD_NONE; // [RULE15] [RULE16]
         endcase
      end
   end

   // ************************************************************
   // Control register.
   // ************************************************************

   // Start bit: set by an accepted start, cleared only by hardware. [RULE11] [RULE12]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_q <= 1'b0;
      end else if (start_ok) begin
         start_q <= 1'b1;
      end else if (state_q == FSC_ST_DONE) begin
         start_q <= 1'b0;
      end
   end

   // Plain read-write fields.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         op_write_enable_q <= 1'b0;
         erase_q <= 1'b0;
         opsel_q <= FSC_OPSEL_RESET;
      end else if (i_reg_wr && (i_reg_sel == FSC_SEL_CTRL)) begin
         op_write_enable_q <= i_reg_wdata[FSC_BIT_OP_WRITE_ENABLE];
         erase_q <= i_reg_wdata[FSC_BIT_ERASE];
         opsel_q <= i_reg_wdata[3:0];
      end
   end

   // Sequence error: a bad start sets it ahead of any clear. [RULE13]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         err_q <= 1'b0;
      end else if (start_bad) begin
         err_q <= 1'b1;
      end else if (state_q == FSC_ST_DONE) begin
         err_q <= 1'b0;
      end else if (i_reg_wr && (i_reg_sel == FSC_SEL_CTRL)) begin
         err_q <= i_reg_wdata[FSC_BIT_ERR];
      end
   end

   // Table page register.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         table_page_q <= FSC_PAGE_RESET;
      end else if (i_reg_wr && (i_reg_sel == FSC_SEL_PAGE)) begin
         table_page_q <= i_reg_wdata[7:0];
      end
   end

   // Read data; the key register always reads zero. [RULE18]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_sel)
            FSC_SEL_CTRL: o_reg_rdata <= {start_q, op_write_enable_q, err_q, 6'h00, erase_q,
                                          2'h0, opsel_q};
            FSC_SEL_PAGE: o_reg_rdata <= {8'h00, table_page_q};
            default: o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ************************************************************
   // Table accesses and holding buffer.
   // ************************************************************
   assign tbl_go = i_tbl_req && (state_q == FSC_ST_IDLE);

   // Latch the full target address of each table write. [RULE7]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tgt_q <= FSC_ADDR_RESET;
      end else if (tbl_go && i_tbl_write) begin
         tgt_q <= {table_page_q, i_tbl_ea};
      end
   end

   // Writes land in the 64-word buffer only, indexed inside the group. [RULE4] [RULE6]
   always_ff @(posedge i_mclk) begin
      if (tbl_go && i_tbl_write) begin
         if (i_tbl_high) begin
            if (!(i_tbl_byte && i_tbl_bsel)) begin
               buf_q[i_tbl_ea[6:1]][23:16] <= i_tbl_wdata[7:0]; // [RULE9]
            end
         end else if (!i_tbl_byte) begin
            buf_q[i_tbl_ea[6:1]][15:0] <= i_tbl_wdata; // [RULE8]
         end else if (i_tbl_bsel) begin
            buf_q[i_tbl_ea[6:1]][15:8] <= i_tbl_wdata[7:0]; // [RULE8]
         end else begin
            buf_q[i_tbl_ea[6:1]][7:0] <= i_tbl_wdata[7:0]; // [RULE8]
         end
      end
   end

   // Write finishes in the next cycle, read one cycle after the array read. [RULE6]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tbl_rd1_q <= 1'b0;
         o_tbl_done <= 1'b0;
      end else begin
         tbl_rd1_q <= tbl_go && !i_tbl_write;
         o_tbl_done <= (tbl_go && i_tbl_write) || tbl_rd1_q;
      end
   end

   // Format read data; the phantom byte always returns zero. [RULE8] [RULE9]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tbl_rdata <= 16'h0000;
      end else if (tbl_go && !i_tbl_write) begin
         o_tbl_rdata <= 16'h0000;
      end else if (tbl_rd1_q) begin
         // Bit 1 of the staged word holds byte mode, bit 0 the upper-byte select gated by byte mode.
         if (o_fl_addr[0]) begin
            if (o_fl_wdata[0]) begin
               o_tbl_rdata <= 16'h0000;
            end else begin
               o_tbl_rdata <= {8'h00, i_fl_rdata[23:16]};
            end
         end else if (o_fl_wdata[1]) begin
            if (o_fl_wdata[0]) begin
               o_tbl_rdata <= {8'h00, i_fl_rdata[15:8]};
            end else begin
               o_tbl_rdata <= {8'h00, i_fl_rdata[7:0]};
            end
         end else begin
            o_tbl_rdata <= i_fl_rdata[15:0];
         end
      end
   end

   // ************************************************************
   // Self-timed sequencer.
   // ************************************************************

   // Duration per command; a no-change command ends at once. [RULE19]
   always_comb begin
      case (cmd_q)
         FSC_CMD_ROW_PROG: lim_d = ROW_RC_CYCLES;
         FSC_CMD_WORD_PROG, FSC_CMD_CFG_PROG: lim_d = WORD_RC_CYCLES;
         FSC_CMD_NONE: lim_d = 16'h0000;
         default: lim_d = ERASE_RC_CYCLES;
      endcase
   end
   assign finish = (rc_cnt_q >= lim_d) && ((cmd_q != FSC_CMD_ROW_PROG) || idx_q[6]);

   // State, command and counters.
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= FSC_ST_IDLE;
         cmd_q <= FSC_CMD_NONE;
         rc_cnt_q <= 16'h0000;
         idx_q <= 7'h00;
      end else begin
         case (state_q)
            FSC_ST_IDLE: begin
               rc_cnt_q <= 16'h0000;
               idx_q <= 7'h00;
               if (start_ok) begin
                  state_q <= FSC_ST_RUN; // [RULE11]
                  cmd_q <= cmd_d;
               end
            end
            FSC_ST_RUN: begin
               if (rc_rise) begin
                  rc_cnt_q <= rc_cnt_q + 16'h0001; // [RULE19]
               end
               if (!idx_q[6]) begin
                  idx_q <= idx_q + 7'h01;
               end
               if (finish) begin
                  state_q <= FSC_ST_DONE;
               end
            end
            FSC_ST_DONE: begin
               state_q <= FSC_ST_IDLE;
               cmd_q <= FSC_CMD_NONE;
            end
            default: begin
               state_q <= FSC_ST_IDLE;
               cmd_q <= FSC_CMD_NONE;
            end
         endcase
      end
   end

   // Core stall while an operation is under way. [RULE10]
   assign o_core_stall = (state_q != FSC_ST_IDLE);
   assign o_fl_cmd = cmd_q;

   // Array strobes, aligned addresses and write data. [RULE1] [RULE3]
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_fl_addr <= FSC_ADDR_RESET;
         o_fl_wdata <= 24'h000000;
         o_fl_wr <= 1'b0;
         o_fl_rd <= 1'b0;
      end else begin
         o_fl_rd <= tbl_go && !i_tbl_write;
         o_fl_wr <= 1'b0;
         if (state_q == FSC_ST_RUN) begin
            case (cmd_q)
               FSC_CMD_ROW_PROG: begin
                  o_fl_addr <= {tgt_q[23:FSC_ROW_LSB], idx_q[5:0], 1'b0};
                  o_fl_wdata <= buf_q[idx_q[5:0]];
                  o_fl_wr <= !idx_q[6];
               end
               FSC_CMD_PAGE_ERASE: begin
                  o_fl_addr <= {tgt_q[23:FSC_PAGE_LSB], 10'h000};
               end
               FSC_CMD_WORD_PROG, FSC_CMD_CFG_PROG: begin
                  o_fl_addr <= tgt_q;
                  o_fl_wdata <= buf_q[tgt_q[6:1]];
                  o_fl_wr <= (idx_q == 7'h00);
               end
               default: begin
                  o_fl_addr <= tgt_q;
               end
            endcase
         end else if (tbl_go && !i_tbl_write) begin
            o_fl_addr <= {table_page_q, i_tbl_ea[15:1], i_tbl_high};
            o_fl_wdata <= {22'h000000, i_tbl_byte, i_tbl_byte && i_tbl_bsel};
         end
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   chk_stall_busy: assert property ( // [RULE10]
      (state_q == FSC_ST_RUN) |-> o_core_stall && start_q)
      else $error("core not stalled during operation");
   chk_start_clear: assert property ( // [RULE11]
      (state_q == FSC_ST_DONE) |=> !start_q && !o_core_stall)
      else $error("start bit not cleared at end");
   chk_start_hold: assert property ( // [RULE12]
      start_q && !(state_q == FSC_ST_DONE) |=> start_q)
      else $error("start bit cleared by software");
   chk_err_set: assert property ( // [RULE13]
      start_bad |=> err_q && (state_q == FSC_ST_IDLE))
      else $error("bad start not flagged");
   chk_need_key: assert property ( // [RULE17]
      (state_q == FSC_ST_IDLE) ##1 (state_q == FSC_ST_RUN) |-> $past(key_armed_q))
      else $error("start taken without key");
   chk_need_op_write_enable: assert property ( // [RULE21]
      start_try && !i_reg_wdata[FSC_BIT_OP_WRITE_ENABLE] |=> state_q == FSC_ST_IDLE)
      else $error("start taken without enable");
   chk_tbl_write: assert property ( // [RULE6]
      tbl_go && i_tbl_write |=> o_tbl_done)
      else $error("table write not done in two cycles");
   chk_tbl_read: assert property ( // [RULE9]
      tbl_go && !i_tbl_write |=> o_fl_rd ##1 o_tbl_done)
      else $error("table read timing wrong");
   chk_row_align: assert property ( // [RULE3]
      o_fl_wr && (cmd_q == FSC_CMD_ROW_PROG) |-> o_fl_addr[23:7] == tgt_q[23:7])
      else $error("row write outside its row");
   chk_key_zero: assert property ( // [RULE18]
      i_reg_rd && (i_reg_sel == FSC_SEL_KEY) |=> o_reg_rdata == 16'h0000)
      else $error("key register read not zero");

endmodule // fsc_flash_ctrl
